// ==== core/fep_pkg.sv ====
/*
 * Package for the flyback estimation and protection block: register map, field layout,
 * reset values, timing constants and shared types.
 * Assumes a 200 MHz APB clock and one aligned 32-bit word per register.
 */
package fep_pkg;
	// Clock
	localparam int CLK_MHZ = 200;
	// Line timing
	localparam int HALF_SINE_PRESET_NS = 9823000;
	localparam int HALF_SINE_PRESET_CYC = HALF_SINE_PRESET_NS / 1000 * CLK_MHZ;
	localparam int SAMPLES_PER_HALF = 64;
	localparam int STARTUP_TIMEOUT_FACTOR = 967;
	localparam int RESTART_DELAY_HALVES = 8;

	// Overcurrent level choices, millivolts
	localparam logic [11:0] OCP2_LVL0_MV = 12'h258;
	localparam logic [11:0] OCP2_LVL1_MV = 12'h320;
	localparam logic [11:0] OCP2_LVL2_MV = 12'h4B0;
	localparam logic [11:0] OCP2_LVL3_MV = 12'h640;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_OCP = 8'h04;
	localparam logic [7:0] REG_UV = 8'h08;
	localparam logic [7:0] REG_OV = 8'h0C;
	localparam logic [7:0] REG_PFC = 8'h10;
	localparam logic [7:0] REG_STARTUP = 8'h14;
	localparam logic [7:0] REG_VIN = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1C;
	localparam logic [7:0] REG_CLEAR = 8'h20;

	// CTRL field positions
	localparam int CTRL_UV_EN = 0;
	localparam int CTRL_UV_REACT = 1;
	localparam int CTRL_OV_REACT = 2;
	localparam int CTRL_BURST_VIN_EN = 3;
	localparam int CTRL_NOTCH_SETTLE_LSB = 8;

	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0400;
	localparam logic [31:0] OCP_RST = 32'h0000_0000;
	localparam logic [31:0] UV_RST = 32'h0000_0000;
	localparam logic [31:0] OV_RST = 32'h0000_0FFF;
	localparam logic [31:0] PFC_RST = 32'h0000_0000;
	localparam logic [31:0] STARTUP_RST = 32'h0000_0001;

	// Protection cause bits
	localparam int CAUSE_OCP = 0;
	localparam int CAUSE_UV = 1;
	localparam int CAUSE_SUV = 2;
	localparam int CAUSE_OV = 3;
	localparam int CAUSE_DEMAG = 4;
	localparam int N_CAUSE = 5;

	typedef enum {ST_OFF, ST_STARTUP, ST_REGULATED, ST_RESTART_WAIT, ST_LATCHED} fep_state_t;

	typedef struct packed {
		logic valley_one_mode;
		logic discontinuous_mode;
		logic burst_mode;
		logic line_sync_valid;
		logic fb_stable;
		logic demag_too_short;
	} fep_mode_t;

	typedef struct packed {
		logic sample_end_on;
		logic [11:0] clamp_current_sample;
		logic [11:0] cs_peak_mv;
		logic [11:0] vout_est;
		logic [19:0] line_period_cyc;
	} fep_sense_t;
endpackage

// ==== core/fep_top.sv ====
/*
 * Flyback estimation and protection block: input voltage estimate, notch and
 * power-factor modulation enables, output and switch protections, APB registers.
 * Assumes sense samples and mode flags come from logic on pclk; the cs comparator
 * level arrives from an analogue pin and is synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - sample clamp current at the next on-time end each 1/64 half period
// - half period is preset or measured line
// - peak input is max of scaled sum
// - rms input is 0.707 of peak
// - rms estimate refreshed once per half period
// - notch on after line sync settles
// - notch quality from configured parameter
// - modulate on-time when gain nonzero, stable
// - zero gain disables power-factor modulation
// - second overcurrent level: smallest above limit, else the highest level
// - overcurrent after blanking, auto-restart unless a latching undervoltage or overvoltage trip comes in the same cycle
// - regulated undervoltage after blanking, selectable reaction
// - regulated undervoltage suspended in burst
// - startup undervoltage at timeout, auto-restart
// - startup timeout is 967 times capacitance
// - overvoltage after quarter of half period, selectable reaction
// - overvoltage not evaluated in burst
// - demag shortage over half of half period, auto-restart
// - demag shortage suspended in burst
// - burst input protection needs its enable
module fep_top import fep_pkg::*; #(
	parameter int HALF_PRESET = HALF_SINE_PRESET_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Sense and mode inputs
	input wire fep_sense_t sense,
	input wire fep_mode_t mode,
	input wire logic cs_above_ocp2_pin,
	input wire logic start_request,
	// Outputs to sequencer
	output logic switching_enable,
	output logic protection_event,
	output logic notch_enable,
	output logic [7:0] notch_quality,
	output logic pf_modulation_enable,
	output logic [7:0] pf_modulation_gain,
	output logic [11:0] overcurrent_level_second,
	output logic burst_input_protect_active,
	output logic [11:0] vin_rms_est
);
	// Registers
	logic [31:0] ctrl_r, ocp_r, uv_r, ov_r, pfc_r, startup_r;
	logic [N_CAUSE-1:0] cause_r, cause_nxt;
	logic [31:0] prdata_r;
	logic [11:0] vin_peak_run_r, vin_rms_r;
	// The preset half period needs 21 bits at this clock rate
	logic [20:0] half_cnt_r, samp_cnt_r;
	logic [19:0] ocp_cnt_r, uv_cnt_r, ov_cnt_r, dm_cnt_r;
	logic [31:0] st_cnt_r;
	logic [7:0] settle_cnt_r;
	logic [3:0] restart_cnt_r;
	logic cs_s1_r, cs_s2_r;
	logic sample_tick_r;
	fep_state_t state_r, state_nxt;

	// Field views
	wire [11:0] low_line_current_limit = ocp_r[11:0];
	wire [15:0] overcurrent_blank_time = ocp_r[31:16];
	wire [11:0] output_uv_threshold = uv_r[11:0];
	wire [15:0] output_uv_blank_time = uv_r[31:16];
	wire [11:0] startup_output_uv_threshold = startup_r[27:16];
	wire [15:0] vcc_cap_value = {4'h0, startup_r[11:0]};
	wire [11:0] output_ov_threshold = ov_r[11:0];
	wire output_uv_enable = ctrl_r[CTRL_UV_EN];
	wire output_uv_reaction_select = ctrl_r[CTRL_UV_REACT];
	wire output_ov_reaction_select = ctrl_r[CTRL_OV_REACT];
	wire burst_input_protect_enable = ctrl_r[CTRL_BURST_VIN_EN];
	wire [7:0] notch_settle = ctrl_r[CTRL_NOTCH_SETTLE_LSB +: 8];

	// Period selection
	wire line_ok = mode.line_sync_valid && !mode.burst_mode && (mode.valley_one_mode || mode.discontinuous_mode);
	wire [20:0] half_period = line_ok ? {1'b0, sense.line_period_cyc} : HALF_PRESET[20:0];
	wire half_end = (half_cnt_r >= half_period - 21'h1);
	wire [20:0] samp_period = {6'h0, half_period[20:6]};
	wire samp_end = (samp_cnt_r >= samp_period - 21'h1) || half_end;
	wire [19:0] quarter_period = {1'h0, half_period[20:2]};
	wire [19:0] half_of_half = half_period[20:1];

	// Input estimate: turns-scaled clamp term plus ripple-scaled cs peak
	wire [7:0] turns_ratio = pfc_r[23:16];
	wire [7:0] ripple_comp = pfc_r[31:24];
	wire [19:0] clamp_term = sense.clamp_current_sample * turns_ratio;
	wire [19:0] cs_term = sense.cs_peak_mv * ripple_comp;
	wire [20:0] vin_sum = {1'b0, clamp_term} + {1'b0, cs_term};
	wire [11:0] vin_inst = (|vin_sum[20:16]) ? 12'hFFF : vin_sum[15:4];
	wire take_sample = sample_tick_r && sense.sample_end_on;
	// 0.707 approximated as 181/256
	wire [19:0] rms_prod = vin_peak_run_r * 8'hB5;

	// Second overcurrent level
	assign overcurrent_level_second = (OCP2_LVL0_MV > low_line_current_limit) ? OCP2_LVL0_MV :
		(OCP2_LVL1_MV > low_line_current_limit) ? OCP2_LVL1_MV :
		(OCP2_LVL2_MV > low_line_current_limit) ? OCP2_LVL2_MV : OCP2_LVL3_MV;

	// Monitor conditions
	wire regulated = (state_r == ST_REGULATED);
	wire ocp_cond = cs_s2_r && switching_enable;
	wire uv_cond = regulated && output_uv_enable && !mode.burst_mode
		&& (sense.vout_est < output_uv_threshold);
	wire ov_cond = regulated && !mode.burst_mode && (sense.vout_est > output_ov_threshold);
	wire dm_cond = regulated && !mode.burst_mode && mode.demag_too_short;
	wire ocp_trip = ocp_cond && (ocp_cnt_r >= {4'h0, overcurrent_blank_time});
	wire uv_trip = uv_cond && (uv_cnt_r >= {4'h0, output_uv_blank_time});
	wire ov_trip = ov_cond && (ov_cnt_r >= quarter_period);
	wire dm_trip = dm_cond && (dm_cnt_r >= half_of_half);
	wire [31:0] st_timeout = vcc_cap_value * STARTUP_TIMEOUT_FACTOR;
	wire st_expired = (state_r == ST_STARTUP) && (st_cnt_r >= st_timeout);
	wire suv_trip = st_expired && (sense.vout_est < startup_output_uv_threshold);
	wire st_done = st_expired && !suv_trip;
	wire latch_hit = (uv_trip && output_uv_reaction_select) || (ov_trip && output_ov_reaction_select);
	wire any_trip = ocp_trip || uv_trip || ov_trip || dm_trip || suv_trip;

	// APB decode
	wire apb_wr = psel && penable && pwrite;
	wire apb_rd = psel && !penable && !pwrite;
	wire addr_ok = (paddr[1:0] == 2'h0) && (paddr <= REG_CLEAR);
	wire clear_wr = apb_wr && (paddr == REG_CLEAR);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = prdata_r;

	// Sequencer state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_OFF: if (start_request) state_nxt = ST_STARTUP;
			ST_STARTUP: begin
				if (any_trip) state_nxt = ST_RESTART_WAIT;
				else if (st_done) state_nxt = ST_REGULATED;
			end
			ST_REGULATED: begin
				if (any_trip) state_nxt = latch_hit ? ST_LATCHED : ST_RESTART_WAIT;
			end
			ST_RESTART_WAIT: if (restart_cnt_r == 4'h0) state_nxt = ST_STARTUP;
			ST_LATCHED: state_nxt = ST_LATCHED;
			default: state_nxt = ST_OFF;
		endcase
	end

	assign switching_enable = (state_r == ST_STARTUP) || (state_r == ST_REGULATED);
	assign protection_event = any_trip && switching_enable;

	// Cause flags: set wins over a software clear
	always_comb begin
		cause_nxt = cause_r;
		if (clear_wr) cause_nxt = cause_r & ~pwdata[N_CAUSE-1:0];
		if (switching_enable) begin
			cause_nxt[CAUSE_OCP] = cause_nxt[CAUSE_OCP] | ocp_trip;
			cause_nxt[CAUSE_UV] = cause_nxt[CAUSE_UV] | uv_trip;
			cause_nxt[CAUSE_SUV] = cause_nxt[CAUSE_SUV] | suv_trip;
			cause_nxt[CAUSE_OV] = cause_nxt[CAUSE_OV] | ov_trip;
			cause_nxt[CAUSE_DEMAG] = cause_nxt[CAUSE_DEMAG] | dm_trip;
		end
	end

	// Notch and modulation
	assign notch_enable = line_ok && (settle_cnt_r >= notch_settle);
	assign notch_quality = pfc_r[15:8];
	assign pf_modulation_gain = pfc_r[7:0];
	assign pf_modulation_enable = (pf_modulation_gain != 8'h00) && mode.fb_stable && regulated
		&& !mode.burst_mode && (mode.valley_one_mode || mode.discontinuous_mode);
	assign burst_input_protect_active = mode.burst_mode ? burst_input_protect_enable : 1'b1;
	assign vin_rms_est = vin_rms_r;

	// Register read mux
	wire [31:0] rd_val = (paddr == REG_CTRL) ? ctrl_r :
		(paddr == REG_OCP) ? ocp_r :
		(paddr == REG_UV) ? uv_r :
		(paddr == REG_OV) ? ov_r :
		(paddr == REG_PFC) ? pfc_r :
		(paddr == REG_STARTUP) ? startup_r :
		(paddr == REG_VIN) ? {20'h0, vin_rms_r} :
		(paddr == REG_STATUS) ? {24'h0, state_r == ST_LATCHED, switching_enable, 1'b0, cause_r} : 32'h0;

	// Pin synchroniser for the cs comparator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_s1_r <= 1'b0;
			cs_s2_r <= 1'b0;
		end else begin
			cs_s1_r <= cs_above_ocp2_pin;
			cs_s2_r <= cs_s1_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RST;
			ocp_r <= OCP_RST;
			uv_r <= UV_RST;
			ov_r <= OV_RST;
			pfc_r <= PFC_RST;
			startup_r <= STARTUP_RST;
			prdata_r <= 32'h0;
		end else begin
			if (apb_wr && paddr == REG_CTRL) ctrl_r <= pwdata;
			if (apb_wr && paddr == REG_OCP) ocp_r <= pwdata;
			if (apb_wr && paddr == REG_UV) uv_r <= pwdata;
			if (apb_wr && paddr == REG_OV) ov_r <= pwdata;
			if (apb_wr && paddr == REG_PFC) pfc_r <= pwdata;
			if (apb_wr && paddr == REG_STARTUP) startup_r <= pwdata;
			if (apb_rd) prdata_r <= rd_val;
		end
	end

	// Line timing and input estimate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_cnt_r <= 21'h0;
			samp_cnt_r <= 21'h0;
			sample_tick_r <= 1'b0;
			vin_peak_run_r <= 12'h0;
			vin_rms_r <= 12'h0;
			settle_cnt_r <= 8'h0;
		end else begin
			half_cnt_r <= half_end ? 21'h0 : half_cnt_r + 21'h1;
			samp_cnt_r <= samp_end ? 21'h0 : samp_cnt_r + 21'h1;
			// Arm once per 1/64 interval, consumed by the next on-time end
			if (samp_end) sample_tick_r <= 1'b1;
			else if (take_sample) sample_tick_r <= 1'b0;
			if (half_end) begin
				vin_rms_r <= rms_prod[19:8];
				vin_peak_run_r <= 12'h0;
			end else if (take_sample && vin_inst > vin_peak_run_r) begin
				vin_peak_run_r <= vin_inst;
			end
			if (!line_ok) settle_cnt_r <= 8'h0;
			else if (half_end && settle_cnt_r != 8'hFF) settle_cnt_r <= settle_cnt_r + 8'h1;
		end
	end

	// Protection timers and sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ocp_cnt_r <= 20'h0;
			uv_cnt_r <= 20'h0;
			ov_cnt_r <= 20'h0;
			dm_cnt_r <= 20'h0;
			st_cnt_r <= 32'h0;
			restart_cnt_r <= 4'h0;
			state_r <= ST_OFF;
			cause_r <= '0;
		end else begin
			ocp_cnt_r <= ocp_cond ? ocp_cnt_r + 20'h1 : 20'h0;
			uv_cnt_r <= uv_cond ? uv_cnt_r + 20'h1 : 20'h0;
			ov_cnt_r <= ov_cond ? ov_cnt_r + 20'h1 : 20'h0;
			dm_cnt_r <= dm_cond ? dm_cnt_r + 20'h1 : 20'h0;
			st_cnt_r <= (state_r == ST_STARTUP) ? st_cnt_r + 32'h1 : 32'h0;
			if (state_r != ST_RESTART_WAIT) restart_cnt_r <= RESTART_DELAY_HALVES[3:0];
			else if (half_end && restart_cnt_r != 4'h0) restart_cnt_r <= restart_cnt_r - 4'h1;
			state_r <= state_nxt;
			cause_r <= cause_nxt;
		end
	end

	a_ocp_stop: assert property (@(posedge pclk) disable iff (!presetn)
		ocp_trip |=> !switching_enable) else $error("overcurrent did not stop switching");
	a_uv_burst: assert property (@(posedge pclk) disable iff (!presetn)
		mode.burst_mode |-> !uv_trip) else $error("undervoltage tripped in burst");
	a_ov_burst: assert property (@(posedge pclk) disable iff (!presetn)
		mode.burst_mode |-> !ov_trip) else $error("overvoltage tripped in burst");
	a_dm_burst: assert property (@(posedge pclk) disable iff (!presetn)
		mode.burst_mode |-> !dm_trip) else $error("demag tripped in burst");
	a_pf_gain_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(pf_modulation_gain == 8'h00) |-> !pf_modulation_enable) else $error("modulation with zero gain");
	a_ocp2_above: assert property (@(posedge pclk) disable iff (!presetn)
		(low_line_current_limit < OCP2_LVL3_MV) |-> (overcurrent_level_second > low_line_current_limit))
		else $error("second level not above limit");
	a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == ST_LATCHED) |=> (state_r == ST_LATCHED) && !switching_enable)
		else $error("latch released");
	a_rms_update: assert property (@(posedge pclk) disable iff (!presetn)
		!half_end |=> $stable(vin_rms_r)) else $error("rms changed mid period");
	a_suv_restart: assert property (@(posedge pclk) disable iff (!presetn)
		(suv_trip && state_r == ST_STARTUP) |=> (state_r == ST_RESTART_WAIT))
		else $error("startup undervoltage not auto-restart");
endmodule
`default_nettype wire

// ==== tb/fep_far_end.sv ====
/* Far-end model: sense samples from the analogue pins.
   Assumes pclk drives everything; the bench sets levels through the _set inputs. */
`timescale 1ns/1ps
`default_nettype none
module fep_far_end import fep_pkg::*; #(
	parameter int HALF = 640
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Levels from the bench
	input wire logic [11:0] vout_set,
	input wire logic [11:0] clamp_set,
	input wire logic [11:0] cs_set,
	// Sense bundle
	output wire fep_sense_t sense
);
	logic [3:0] cnt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
	// Alternate amplitude so a peak estimate must be a true maximum
	assign sense.sample_end_on = (cnt_r[2:0] == 3'h7);
	assign sense.clamp_current_sample = cnt_r[3] ? clamp_set : (clamp_set >> 1);
	assign sense.cs_peak_mv = cs_set;
	assign sense.vout_est = vout_set;
	assign sense.line_period_cyc = 20'(HALF);
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
/* Bench for the estimation and protection block: APB tasks and call sequences.
   Assumes a shortened half period so trips and restarts fit a short run. */
`timescale 1ns/1ps
`default_nettype none
module tb import fep_pkg::*;;
	localparam int HALF = 640;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic cs_pin = 1'b0;
	logic start_req = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, err, sw_en, prot_ev, notch_en, pf_en, bip;
	logic [7:0] nq, pfg;
	logic [11:0] ocp2, vin_rms;
	logic [11:0] vout = 12'h200, clamp = 12'h400, csv = 12'h000;
	fep_mode_t mode = '0;
	fep_sense_t sense;
	int miscompares = 0, check_count = 0, n;
	logic [7:0] ra[6] = '{REG_CTRL, REG_OCP, REG_UV, REG_OV, REG_PFC, REG_STARTUP};
	logic [31:0] rv[6] = '{CTRL_RST, OCP_RST, UV_RST, OV_RST, PFC_RST, STARTUP_RST};
	logic [11:0] lim[7] = '{12'h000, 12'h257, 12'h258, 12'h31F, 12'h320, 12'h63F, 12'h4B0};
	logic [11:0] lvl[7] = '{OCP2_LVL0_MV, OCP2_LVL0_MV, OCP2_LVL1_MV, OCP2_LVL1_MV,
		OCP2_LVL2_MV, OCP2_LVL3_MV, OCP2_LVL3_MV};

	fep_top #(.HALF_PRESET(HALF)) u_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sense(sense), .mode(mode), .cs_above_ocp2_pin(cs_pin),
		.start_request(start_req), .switching_enable(sw_en), .protection_event(prot_ev),
		.notch_enable(notch_en), .notch_quality(nq), .pf_modulation_enable(pf_en),
		.pf_modulation_gain(pfg), .overcurrent_level_second(ocp2),
		.burst_input_protect_active(bip), .vin_rms_est(vin_rms));
	fep_far_end #(.HALF(HALF)) u_far(.pclk(pclk), .presetn(presetn), .vout_set(vout),
		.clamp_set(clamp), .cs_set(csv), .sense(sense));

	initial begin
		forever #2.5 pclk = ~pclk;
	end

	task automatic end_sim;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask
	// Ends one idle edge after release so the next call never drives psel twice in a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++t < 20);
		if (t >= 20) miscompares++;
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(s, e, rdat);
	endtask
	task automatic wait_sw(input logic v, input int lmt);
		n = 0;
		while (sw_en !== v && n < lmt) begin
			@(posedge pclk);
			n++;
		end
	endtask
	task automatic reset_dut;
		presetn <= 1'b0;
		start_req <= 1'b0;
		cyc(4);
		presetn <= 1'b1;
		cyc(1);
	endtask
	task automatic back_on;
		apb(1'b1, REG_CLEAR, 32'h1F);
		wait_sw(1'b1, 9 * HALF);
		chk("restart delay", 1, 32'(n inside {[7 * HALF - 50 : 9 * HALF - 1]}));
		cyc(2100);
		chk("regulated", 1, 32'(sw_en));
	endtask

	initial begin
		#500000;
		miscompares++;
		end_sim;
	end

	initial begin
		reset_dut;
		foreach (ra[i]) rchk("reset value", ra[i], rv[i]);
		apb(1'b0, 8'h24, 32'h0);
		chk("unmapped err", 1, 32'(err));
		chk("unmapped data", 0, rdat);
		apb(1'b1, REG_OV, 32'h123);
		rchk("ov readback", REG_OV, 32'h123);
		foreach (lim[i]) begin
			apb(1'b1, REG_OCP, {20'h0, lim[i]});
			chk("ocp level", 32'(lvl[i]), 32'(ocp2));
		end
		mode.valley_one_mode <= 1'b1;
		mode.fb_stable <= 1'b1;
		apb(1'b1, REG_PFC, 32'h1010_3300);
		chk("pf off", 0, 32'(pf_en));
		chk("quality", 32'h33, 32'(nq));
		apb(1'b1, REG_PFC, 32'h1010_3305);
		chk("pf idle", 0, 32'(pf_en));
		chk("pf gain", 5, 32'(pfg));
		cyc(3 * HALF);
		chk("vin rms", 32'h2D4, 32'(vin_rms));
		csv <= 12'h100;
		clamp <= 12'h200;
		cyc(3 * HALF);
		rchk("vin reg", REG_VIN, 32'h21F);
		apb(1'b1, REG_CTRL, 32'h0000_0200);
		mode.line_sync_valid <= 1'b1;
		cyc(2);
		chk("notch early", 0, 32'(notch_en));
		cyc(4 * HALF);
		chk("notch on", 1, 32'(notch_en));
		mode.burst_mode <= 1'b1;
		cyc(2);
		chk("notch burst", 0, 32'(notch_en));
		chk("burst vin off", 0, 32'(bip));
		apb(1'b1, REG_CTRL, 32'h0000_0208);
		chk("burst vin on", 1, 32'(bip));
		mode.burst_mode <= 1'b0;
		mode.line_sync_valid <= 1'b0;
		reset_dut;
		apb(1'b1, REG_STARTUP, 32'h0100_0002);
		vout <= 12'h050;
		start_req <= 1'b1;
		cyc(1900);
		chk("startup run", 1, 32'(sw_en));
		wait_sw(1'b0, 100);
		chk("startup uv", 1, 32'(n inside {[20:50]}));
		rchk("status suv", REG_STATUS, 32'h04);
		vout <= 12'h200;
		back_on;
		apb(1'b1, REG_PFC, 32'h1010_3305);
		chk("pf on", 1, 32'(pf_en));
		apb(1'b1, REG_OCP, 32'h0010_0000);
		cs_pin <= 1'b1;
		cyc(8);
		cs_pin <= 1'b0;
		cyc(4);
		chk("ocp short", 1, 32'(sw_en));
		cs_pin <= 1'b1;
		wait_sw(1'b0, 60);
		cs_pin <= 1'b0;
		chk("ocp trip", 1, 32'(n inside {[15:24]}));
		rchk("status ocp", REG_STATUS, 32'h01);
		back_on;
		apb(1'b1, REG_OV, 32'h300);
		mode.burst_mode <= 1'b1;
		vout <= 12'h400;
		cyc(300);
		chk("ov burst", 1, 32'(sw_en));
		mode.burst_mode <= 1'b0;
		wait_sw(1'b0, 200);
		chk("ov trip", 1, 32'(n inside {[155:168]}));
		rchk("status ov", REG_STATUS, 32'h08);
		vout <= 12'h200;
		back_on;
		mode.burst_mode <= 1'b1;
		mode.demag_too_short <= 1'b1;
		cyc(400);
		chk("demag burst", 1, 32'(sw_en));
		mode.burst_mode <= 1'b0;
		wait_sw(1'b0, 400);
		chk("demag trip", 1, 32'(n inside {[315:330]}));
		rchk("status demag", REG_STATUS, 32'h10);
		mode.demag_too_short <= 1'b0;
		back_on;
		apb(1'b1, REG_CTRL, 32'h0000_0403);
		apb(1'b1, REG_UV, 32'h0014_0100);
		mode.burst_mode <= 1'b1;
		vout <= 12'h050;
		cyc(100);
		chk("uv burst", 1, 32'(sw_en));
		mode.burst_mode <= 1'b0;
		wait_sw(1'b0, 60);
		chk("uv trip", 1, 32'(n inside {[18:28]}));
		rchk("status uv", REG_STATUS, 32'h82);
		cyc(10 * HALF);
		chk("latched", 0, 32'(sw_en));
		end_sim;
	end
endmodule
`default_nettype wire
